// ===== conversion_status_serial_out_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module conversion_status_serial_out_tb;
import csso_pkg::*;
logic sys_clk_i = 0, rst_n_i = 0, hold_n_i = 1, select_n_i = 1, read_n_i = 1;
logic cal_req_i = 0, master_clock_in = 0, conv_done_o, acquire_done_n_o;
logic serial_result_out_o, serial_clk_o, comparator_i;
logic [RES_BITS-1:0] dac_trial_o, level = 16'h0000, word;
int failures = 0, checks = 0, cyc = 0, n, bits, b0;
initial forever #12.5 sys_clk_i = ~sys_clk_i;
initial begin #3.7; forever #3 master_clock_in = ~master_clock_in; end
csso_core csso_core_i (.sys_clk_i, .rst_n_i, .hold_n_i, .select_n_i, .read_n_i, .cal_req_i,
    .factory_test_tie_i(1'b0), .conv_done_o, .acquire_done_n_o, .master_clock_in,
    .comparator_i, .dac_trial_o, .serial_result_out_o, .serial_clk_o);
csso_host_model csso_host_model_i (.level_i(level), .trial_i(dac_trial_o), .cmp_o(comparator_i),
    .sclk_i(serial_clk_o), .serial_result_out_i(serial_result_out_o), .word_o(word), .bits_o(bits));
task automatic tick(int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
endtask : tick
task automatic wait_fall();
    n = 0;
    while (conv_done_o !== 1'b0 && n < 200) begin tick(1); n++; end
endtask : wait_fall
task automatic conv(logic [15:0] v);
    level = v;
    b0 = bits;
    @(posedge sys_clk_i) hold_n_i <= 0;
    tick(6);
    `CHK("busy", 1'b1, conv_done_o)
    `CHK("acq_hi", 1'b1, acquire_done_n_o)
    @(posedge sys_clk_i) hold_n_i <= 1;
    wait_fall();
    `CHK("done", 1'b0, conv_done_o)
    `CHK("word", v, word)
    `CHK("nbits", 16, bits - b0)
    `CHK("trial", v, dac_trial_o)
    `CHK("serial_result_out_lsb", v[0], serial_result_out_o)
    n = 0;
    while (acquire_done_n_o !== 1'b0 && n < 100) begin tick(1); n++; end
    `CHK("acq_wait", int'(ACQ_CYCLES), n)
endtask : conv
task automatic t_read();
    conv(16'hA5C3);
    @(posedge sys_clk_i) read_n_i <= 0;
    tick(6);
    `CHK("no_sel", 1'b0, conv_done_o)
    @(posedge sys_clk_i) select_n_i <= 0;
    tick(6);
    `CHK("read_rise", 1'b1, conv_done_o)
    @(posedge sys_clk_i) begin select_n_i <= 1; read_n_i <= 1; end
    $display("test read done");
endtask : t_read
task automatic t_b2b();
    conv(16'hFFFF);
    conv(16'h0000);
    conv(16'h8001);
    $display("test back to back done");
endtask : t_b2b
task automatic t_cal();
    b0 = bits;
    @(posedge sys_clk_i) cal_req_i <= 1;
    tick(6);
    `CHK("cal_busy", 1'b1, conv_done_o)
    @(posedge sys_clk_i) cal_req_i <= 0;
    wait_fall();
    `CHK("cal_end", 1'b0, conv_done_o)
    `CHK("cal_quiet", 0, bits - b0)
    $display("test calibration done");
endtask : t_cal
task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask : test_done
always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin failures++; test_done(); end
end
initial begin
    tick(2);
    `CHK("rst_out", 3'b101, {conv_done_o, acquire_done_n_o, serial_clk_o})
    @(posedge sys_clk_i) rst_n_i <= 1;
    tick(2);
    t_read();
    t_b2b();
    t_cal();
    test_done();
end
endmodule : conversion_status_serial_out_tb
bind csso_core csso_monitor csso_monitor_i (.sys_clk_i, .rst_n_i, .hold_n_i, .select_n_i,
    .read_n_i, .cal_req_i, .conv_done_o, .acquire_done_n_o, .master_clock_in,
    .serial_result_out_o, .serial_clk_o);

// ===== csso_core.sv
`timescale 1ns/10ps
module csso_core import csso_pkg::*; (
    // system side
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // host pins
    input wire logic hold_n_i,
    input wire logic select_n_i,
    input wire logic read_n_i,
    input wire logic cal_req_i,
    input wire logic factory_test_tie_i,
    // status
    output logic conv_done_o,
    output logic acquire_done_n_o,
    // link side, timed by the master clock
    input wire logic master_clock_in,
    input wire logic comparator_i,
    output logic [RES_BITS-1:0] dac_trial_o,
    output logic serial_result_out_o,
    output logic serial_clk_o
);

    ////////////////////////////////////////////////////////////////////////
    // state of both domains

    csso_sys_t s_q;
    csso_sys_t s_d;

    csso_link_t l_q;
    csso_link_t l_d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic fell(input logic prev, input logic cur);
        return prev & ~cur;
    endfunction : fell

    function automatic logic rose(input logic prev, input logic cur);
        return ~prev & cur;
    endfunction : rose

    function automatic logic tgl_evt(input logic a, input logic b);
        return a ^ b;
    endfunction : tgl_evt

    ////////////////////////////////////////////////////////////////////////
    // system domain: start requests, status flags

    logic start_conv;
    logic start_cal;
    logic read_edge;
    logic done_evt;

    always_comb begin
        s_d = s_q;

        // host pins, two flops each before use
        s_d.hold_s1 = hold_n_i;
        s_d.hold_s2 = s_q.hold_s1;
        s_d.hold_prev = s_q.hold_s2;

        s_d.cs_s1 = select_n_i;
        s_d.cs_s2 = s_q.cs_s1;

        s_d.rd_s1 = read_n_i;
        s_d.rd_s2 = s_q.rd_s1;

        s_d.cal_s1 = cal_req_i;
        s_d.cal_s2 = s_q.cal_s1;
        s_d.cal_prev = s_q.cal_s2;

        s_d.tst_s1 = factory_test_tie_i;
        s_d.tst_s2 = s_q.tst_s1;

        // cycle-end toggle coming over from the link domain
        s_d.done_s1 = l_q.done_tgl;
        s_d.done_s2 = s_q.done_s1;
        s_d.done_prev = s_q.done_s2;

        // a strapped-high test pin blocks all cycles rather than guessing its use
        start_conv = fell(s_q.hold_prev, s_q.hold_s2)
            & ~s_q.busy
            & ~s_q.tst_s2;

        // conversion wins when both requests land together
        start_cal = rose(s_q.cal_prev, s_q.cal_s2)
            & ~s_q.busy
            & ~s_q.tst_s2
            & ~start_conv;

        // edge of the access, so a long strobe counts once
        s_d.acc_prev = ~s_q.cs_s2 & ~s_q.rd_s2;
        read_edge = ~s_q.cs_s2 & ~s_q.rd_s2 & ~s_q.acc_prev;

        done_evt = tgl_evt(s_q.done_s2, s_q.done_prev);

        if (read_edge) begin
            s_d.eoc = 1'b1;
        end
        if (start_conv | start_cal) begin
            s_d.conv_tgl = s_q.conv_tgl ^ start_conv;
            s_d.cal_tgl = s_q.cal_tgl ^ start_cal;
            s_d.busy = 1'b1;
            s_d.eoc = 1'b1;
            s_d.eot_n = 1'b1;
            s_d.acq_cnt = ACQ_RST;
        end
        if (done_evt) begin
            // end of cycle wins over a read in the same cycle
            s_d.busy = 1'b0;
            s_d.eoc = 1'b0;
            s_d.acq_cnt = ACQ_RST;
        end else if (!s_q.busy && s_q.eot_n) begin
            if (s_q.acq_cnt == ACQ_CYCLES - 8'h01) begin
                s_d.eot_n = 1'b0;
            end else begin
                s_d.acq_cnt = s_q.acq_cnt + 8'h01;
            end
        end
    end

    // pins reset to their idle levels so no false edge follows reset
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.hold_s1 <= 1'b1;
            s_q.hold_s2 <= 1'b1;
            s_q.hold_prev <= 1'b1;
            s_q.cs_s1 <= 1'b1;
            s_q.cs_s2 <= 1'b1;
            s_q.rd_s1 <= 1'b1;
            s_q.rd_s2 <= 1'b1;
            s_q.acc_prev <= 1'b0;
            s_q.cal_s1 <= 1'b0;
            s_q.cal_s2 <= 1'b0;
            s_q.cal_prev <= 1'b0;
            s_q.tst_s1 <= 1'b0;
            s_q.tst_s2 <= 1'b0;
            s_q.done_s1 <= 1'b0;
            s_q.done_s2 <= 1'b0;
            s_q.done_prev <= 1'b0;
            s_q.conv_tgl <= 1'b0;
            s_q.cal_tgl <= 1'b0;
            s_q.busy <= 1'b0;
            s_q.eoc <= 1'b1;
            // nothing to acquire over right after reset
            s_q.eot_n <= 1'b0;
            s_q.acq_cnt <= ACQ_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign conv_done_o = s_q.eoc;
    assign acquire_done_n_o = s_q.eot_n;

    ////////////////////////////////////////////////////////////////////////
    // link domain: successive approximation and serial shift-out

    logic conv_evt;
    logic cal_evt;
    logic decision;

    always_comb begin
        l_d = l_q;

        // start toggles from the system domain, two flops each
        l_d.conv_s1 = s_q.conv_tgl;
        l_d.conv_s2 = l_q.conv_s1;
        l_d.conv_seen = l_q.conv_s2;

        l_d.cal_s1 = s_q.cal_tgl;
        l_d.cal_s2 = l_q.cal_s1;
        l_d.cal_seen = l_q.cal_s2;

        // comparator is analog, so it is treated as asynchronous
        l_d.cmp_s1 = comparator_i;
        l_d.cmp_s2 = l_q.cmp_s1;

        conv_evt = tgl_evt(l_q.conv_s2, l_q.conv_seen);
        cal_evt = tgl_evt(l_q.cal_s2, l_q.cal_seen);

        // comparator high keeps the trial bit
        decision = l_q.cmp_s2;
        case (l_q.state)
            CSSO_IDLE: begin
                l_d.phase = 2'h0;
                if (conv_evt) begin
                    l_d.state = CSSO_CONV;
                    l_d.bit_idx = MSB_IDX;
                    l_d.trial = '0;
                    l_d.trial[MSB_IDX] = 1'b1;
                end else if (cal_evt) begin
                    l_d.state = CSSO_CAL;
                    l_d.cal_cnt = CAL_RST;
                end
            end
            CSSO_CONV: begin
                l_d.phase = l_q.phase + 2'h1;
                // phases 0..2 let the trial settle through the comparator sync
                if (l_q.phase == PH_SCLK_RISE) begin
                    l_d.sclk = 1'b1;
                end
                if (l_q.phase == PH_DECIDE) begin
                    l_d.trial[l_q.bit_idx] = decision;
                    l_d.serial_result_out = decision;
                    l_d.sclk = 1'b0;
                    if (l_q.bit_idx == '0) begin
                        l_d.state = CSSO_TAIL;
                    end else begin
                        l_d.trial[l_q.bit_idx - 4'h1] = 1'b1;
                        l_d.bit_idx = l_q.bit_idx - 4'h1;
                    end
                end
            end
            CSSO_TAIL: begin
                l_d.phase = l_q.phase + 2'h1;
                if (l_q.phase == PH_SCLK_RISE) begin
                    l_d.sclk = 1'b1;
                    l_d.done_tgl = ~l_q.done_tgl;
                    l_d.state = CSSO_IDLE;
                end
            end
            CSSO_CAL: begin
                l_d.cal_cnt = l_q.cal_cnt + 8'h01;
                if (l_q.cal_cnt == CAL_CYCLES - 8'h01) begin
                    l_d.done_tgl = ~l_q.done_tgl;
                    l_d.state = CSSO_IDLE;
                end
            end
            default: begin
                l_d.state = CSSO_IDLE;
            end
        endcase
    end

    // bit clock idles high so the first falling edge opens a frame
    always_ff @(posedge master_clock_in or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_q.conv_s1 <= 1'b0;
            l_q.conv_s2 <= 1'b0;
            l_q.conv_seen <= 1'b0;
            l_q.cal_s1 <= 1'b0;
            l_q.cal_s2 <= 1'b0;
            l_q.cal_seen <= 1'b0;
            l_q.cmp_s1 <= 1'b0;
            l_q.cmp_s2 <= 1'b0;
            l_q.state <= CSSO_IDLE;
            l_q.phase <= 2'h0;
            l_q.bit_idx <= MSB_IDX;
            l_q.trial <= '0;
            l_q.cal_cnt <= CAL_RST;
            l_q.done_tgl <= 1'b0;
            l_q.serial_result_out <= 1'b0;
            l_q.sclk <= 1'b1;
        end else begin
            l_q <= l_d;
        end
    end

    assign dac_trial_o = l_q.trial;
    assign serial_result_out_o = l_q.serial_result_out;
    assign serial_clk_o = l_q.sclk;

endmodule : csso_core

// ===== csso_host_model.sv
`timescale 1ns/10ps
module csso_host_model import csso_pkg::*; (
    // analog stand-in
    input wire logic [RES_BITS-1:0] level_i,
    input wire logic [RES_BITS-1:0] trial_i,
    output logic cmp_o,
    // serial receiver
    input wire logic sclk_i,
    input wire logic serial_result_out_i,
    output logic [RES_BITS-1:0] word_o,
    output int bits_o
);
assign cmp_o = level_i >= trial_i;
initial bits_o = 0;
// shift in on the rising bit clock, msb lands first
always @(posedge sclk_i) begin
    word_o <= {word_o[RES_BITS-2:0], serial_result_out_i};
    bits_o <= bits_o + 1;
end
endmodule : csso_host_model

// ===== csso_monitor.sv
`timescale 1ns/10ps
module csso_monitor (
    // system side
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic hold_n_i,
    input wire logic select_n_i,
    input wire logic read_n_i,
    input wire logic cal_req_i,
    input wire logic conv_done_o,
    input wire logic acquire_done_n_o,
    // link side
    input wire logic master_clock_in,
    input wire logic serial_result_out_o,
    input wire logic serial_clk_o
);
////////////////////////////////////////////////////////////////////////
property p_acq_settle;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $fell(acquire_done_n_o) |-> $past(acquire_done_n_o, 8);
endproperty
a_acq_settle: assert property (p_acq_settle) else $error("acq fell early");
property p_start_both;
    @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(acquire_done_n_o) |-> conv_done_o;
endproperty
a_start_both: assert property (p_start_both) else $error("start not busy");
property p_busy_high;
    @(posedge sys_clk_i) disable iff (!rst_n_i) !serial_clk_o |-> conv_done_o;
endproperty
a_busy_high: assert property (p_busy_high) else $error("done low mid cycle");
// a rise needs a read, a start or a calibration behind it
property p_done_rise;
    @(posedge sys_clk_i) disable iff (!rst_n_i) $rose(conv_done_o) |->
    (!$past(read_n_i, 2) && !$past(select_n_i, 2)) || !$past(hold_n_i, 2) || $past(cal_req_i, 2);
endproperty
a_done_rise: assert property (p_done_rise) else $error("done rose uncaused");
////////////////////////////////////////////////////////////////////////
property p_sclk_low;
    @(posedge master_clock_in) disable iff (!rst_n_i)
    $fell(serial_clk_o) |=> !serial_clk_o ##1 serial_clk_o;
endproperty
a_sclk_low: assert property (p_sclk_low) else $error("bit clock low width");
property p_sclk_high;
    @(posedge master_clock_in) disable iff (!rst_n_i) $rose(serial_clk_o) |-> serial_clk_o [*2];
endproperty
a_sclk_high: assert property (p_sclk_high) else $error("bit clock high width");
property p_data_stable;
    @(posedge master_clock_in) disable iff (!rst_n_i)
    $rose(serial_clk_o) |-> $stable(serial_result_out_o);
endproperty
a_data_stable: assert property (p_data_stable) else $error("data moved at rise");
property p_data_chg;
    @(posedge master_clock_in) disable iff (!rst_n_i)
    $changed(serial_result_out_o) |-> $fell(serial_clk_o);
endproperty
a_data_chg: assert property (p_data_chg) else $error("data moved off bit");
endmodule : csso_monitor

// ===== csso_pkg.sv
package csso_pkg;

    localparam int RES_BITS = 16;
    localparam int IDX_W = 4;
    localparam int SYS_CLK_PERIOD_NS = 25;
    // settle time of the input track stage, counted from the end of a cycle
    localparam int ACQ_TIME_NS = 1000;
    localparam logic [7:0] ACQ_CYCLES =
        8'((ACQ_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS);
    // length of one calibration cycle in link clocks
    localparam logic [7:0] CAL_CYCLES = 8'h40;
    localparam logic [1:0] PH_DECIDE = 2'h3;
    localparam logic [1:0] PH_SCLK_RISE = 2'h1;
    localparam logic [IDX_W-1:0] MSB_IDX = 4'hF;
    localparam logic [7:0] ACQ_RST = 8'h00;
    localparam logic [7:0] CAL_RST = 8'h00;

    typedef enum logic [1:0] {
        CSSO_IDLE,
        CSSO_CONV,
        CSSO_CAL,
        CSSO_TAIL
    } csso_state_t;

    typedef struct packed {
        logic hold_s1;
        logic hold_s2;
        logic hold_prev;
        logic cs_s1;
        logic cs_s2;
        logic rd_s1;
        logic rd_s2;
        logic acc_prev;
        logic cal_s1;
        logic cal_s2;
        logic cal_prev;
        logic tst_s1;
        logic tst_s2;
        logic done_s1;
        logic done_s2;
        logic done_prev;
        logic conv_tgl;
        logic cal_tgl;
        logic busy;
        logic eoc;
        logic eot_n;
        logic [7:0] acq_cnt;
    } csso_sys_t;

    typedef struct packed {
        logic conv_s1;
        logic conv_s2;
        logic conv_seen;
        logic cal_s1;
        logic cal_s2;
        logic cal_seen;
        logic cmp_s1;
        logic cmp_s2;
        csso_state_t state;
        logic [1:0] phase;
        logic [IDX_W-1:0] bit_idx;
        logic [RES_BITS-1:0] trial;
        logic [7:0] cal_cnt;
        logic done_tgl;
        logic serial_result_out;
        logic sclk;
    } csso_link_t;

endpackage : csso_pkg
